// [hdl/tmr_consts.svh]
// timer1 constants: register indices, field masks, reset values, codes
// assumes each timer file that uses it includes it by bare name; definitions only
// Operation
// - clock select picks stop, clock, prescaled, external
// - external clock input sampled on rising clock
// - pin action field: off, toggle, low, high
// - pin driven only when direction bit set
// - reserved control bits read as zero
// - pwm field selects off, 8, 9, 10 bits
// - pwm gives two glitch-free centred outputs
// - filter needs four equal samples before capture
// - unfiltered capture on first sampled edge
// - capture copies counter; edge select picks polarity
// - comparator output may trigger capture
// - clear counter cycle after channel A match
// - prescaled clear shows value plus one first
// - clear on match ignored in pwm
// - flags for overflow, two matches, capture
// - capture low read latches high byte
// - match flag next cycle; writes never match
// - pwm counts zero to top and back
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH
`define TMR_IDX_W 6
`define TMR_IDX_CAP_L 6'h26
`define TMR_IDX_CAP_H 6'h27
`define TMR_IDX_OCB_L 6'h28
`define TMR_IDX_OCB_H 6'h29
`define TMR_IDX_OCA_L 6'h2A
`define TMR_IDX_OCA_H 6'h2B
`define TMR_IDX_CNT_L 6'h2C
`define TMR_IDX_CNT_H 6'h2D
`define TMR_IDX_CTL_B 6'h2E
`define TMR_IDX_CTL_A 6'h2F
`define TMR_IDX_AUX 6'h30
`define TMR_IDX_FLAG 6'h38
`define TMR_IDX_MASK 6'h39
`define TMR_CTLA_WMASK 8'hF3
`define TMR_CTLB_WMASK 8'hCF
`define TMR_CTL_RST 8'h00
`define TMR_COM_OFF 2'h0
`define TMR_COM_TOGGLE 2'h1
`define TMR_COM_LOW 2'h2
`define TMR_COM_HIGH 2'h3
`define TMR_PWM_OFF 2'h0
`define TMR_PWM_8 2'h1
`define TMR_PWM_9 2'h2
`define TMR_TOP_8 16'h00FF
`define TMR_TOP_9 16'h01FF
`define TMR_TOP_10 16'h03FF
`define TMR_PWM_CMP_MASK 16'h03FF
`define TMR_FLG_OVF 0
`define TMR_FLG_CMPA 1
`define TMR_FLG_CMPB 2
`define TMR_FLG_CAP 3
`define TMR_NC_SAMPLES 4
`define TMR_PRE_W 10
`define TMR_TAP_8 3
`define TMR_TAP_64 6
`define TMR_TAP_256 8
`define TMR_TAP_1024 10
`endif

// [hdl/tmr_pkg.sv]
// timer1 types: clock select codes and control register layouts
// assumes compilation before every timer module
package tmr_pkg;
	typedef enum logic [2:0] {
		TMR_CS_STOP = 3'b000,
		TMR_CS_CLK = 3'b001,
		TMR_CS_DIV8 = 3'b010,
		TMR_CS_DIV64 = 3'b011,
		TMR_CS_DIV256 = 3'b100,
		TMR_CS_DIV1024 = 3'b101,
		TMR_CS_EXT_FALL = 3'b110,
		TMR_CS_EXT_RISE = 3'b111
	} tmr_cs_e;
	typedef struct packed {
		logic [1:0] compare_a_pin_action;
		logic [1:0] compare_b_pin_action;
		logic [1:0] rsvd;
		logic [1:0] pwm_resolution;
	} tmr_ctla_s;
	typedef struct packed {
		logic capture_noise_filter_en;
		logic capture_edge_select;
		logic [1:0] rsvd;
		logic clear_on_match_a;
		tmr_cs_e clock_select;
	} tmr_ctlb_s;
	typedef struct packed {
		logic dir_b;
		logic dir_a;
		logic cap_from_cmp;
	} tmr_aux_s;
endpackage

// [hdl/tmr_sync3.sv]
// three-stage input synchroniser with agreement filter, per bit
// assumes inputs asynchronous to clk; outputs registered
`timescale 1ns/10ps
module tmr_sync3
	import tmr_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] level_o,
	output logic [WIDTH-1:0] rise_o,
	output logic [WIDTH-1:0] fall_o
);
	if (WIDTH < 1) begin : g_chk
		$error("tmr_sync3: WIDTH must be at least one");
	end
	logic [WIDTH-1:0] s1_q, s2_q, s3_q;
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		// a change counts only once stages two and three agree
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				s1_q[i] <= 1'b0;
				s2_q[i] <= 1'b0;
				s3_q[i] <= 1'b0;
				level_o[i] <= 1'b0;
				rise_o[i] <= 1'b0;
				fall_o[i] <= 1'b0;
			end else begin
				s1_q[i] <= async_i[i];
				s2_q[i] <= s1_q[i];
				s3_q[i] <= s2_q[i];
				if (s2_q[i] == s3_q[i]) begin
					level_o[i] <= s3_q[i];
				end
				rise_o[i] <= (s2_q[i] == s3_q[i]) && s3_q[i] && !level_o[i];
				fall_o[i] <= (s2_q[i] == s3_q[i]) && !s3_q[i] && level_o[i];
			end
		end
	end
endmodule

// [hdl/tmr_prescale.sv]
// free-running prescaler giving one-cycle ticks at clk/8, /64, /256, /1024
// assumes one clock; taps are registered pulses
`timescale 1ns/10ps
`include "tmr_consts.svh"
module tmr_prescale
	import tmr_pkg::*;
#(
	parameter int PRE_W = `TMR_PRE_W
) (
	input wire logic clk,
	input wire logic rst_n,
	output logic [3:0] tap_o
);
	localparam int TAP_BIT [4] = '{`TMR_TAP_8, `TMR_TAP_64, `TMR_TAP_256, `TMR_TAP_1024};
	if (PRE_W < `TMR_TAP_1024) begin : g_chk
		$error("tmr_prescale: PRE_W too small for the widest tap");
	end
	logic [PRE_W-1:0] pre_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_q <= '0;
		end else begin
			pre_q <= pre_q + 1'b1;
		end
	end
	for (genvar i = 0; i < 4; i++) begin : g_tap
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				tap_o[i] <= 1'b0;
			end else begin
				tap_o[i] <= &pre_q[TAP_BIT[i]-1:0];
			end
		end
	end
endmodule

// [hdl/tmr_timer1.sv]
// 16-bit timer with prescaler, two compare channels, pwm and capture
// assumes a single AHB-Lite master, zero wait states, byte data in bits 7:0
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/10ps
`include "tmr_consts.svh"
module tmr_timer1
	import tmr_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic external_count_input,
	input wire logic capture_input_pin,
	input wire logic analog_cmp_i,
	output logic compare_output_a,
	output logic compare_output_a_oe,
	output logic compare_output_b,
	output logic compare_output_b_oe
);
	if (CNT_W != 16) begin : g_chk
		$error("tmr_timer1: byte-paired registers need CNT_W of 16");
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	tmr_ctla_s ctla_q;
	tmr_ctlb_s ctlb_q;
	tmr_aux_s aux_q;
	logic [3:0] flg_q, msk_q;
	logic [7:0] temp_q, rd_byte, wb;
	logic [CNT_W-1:0] cnt_q, cnt_d, cap_q, top;
	logic [CNT_W-1:0] ocr_q [2];
	logic [CNT_W-1:0] obuf_q [2];
	logic [CNT_W-1:0] eff [2];
	logic [1:0] com [2];
	logic [1:0] dir, hit, hit_q, hit_up_q, at_q, oc_q, oe_q;
	logic up_q, up_d, cnt_step, tick, pwm_on, clr_pend_q, ovf_ev;
	logic wr_pend_q, cnt_wr, rd_acc, wr_acc;
	logic [`TMR_IDX_W-1:0] wr_idx_q, rd_idx;
	logic [2:0] sync_lvl, sync_rise, sync_fall;
	logic [3:0] pre_tap;
	logic [3:0] nc_q;
	logic cap_src, filt_q, filt_d, cap_ev;
	logic [31:0] hrdata_q;
	logic hready_q;

	tmr_sync3 #(.WIDTH(3)) u_sync (
		.clk(hclk),
		.rst_n(hresetn),
		.async_i({analog_cmp_i, capture_input_pin, external_count_input}),
		.level_o(sync_lvl),
		.rise_o(sync_rise),
		.fall_o(sync_fall)
	);

	tmr_prescale #(.PRE_W(`TMR_PRE_W)) u_pre (
		.clk(hclk),
		.rst_n(hresetn),
		.tap_o(pre_tap)
	);

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	// registers are bytes; size is not checked, all answers are OKAY
	assign rd_idx = haddr[`TMR_IDX_W+1:2];
	assign rd_acc = hsel && htrans[1] && hready && !hwrite;
	assign wr_acc = hsel && htrans[1] && hready && hwrite;
	assign wb = hwdata[7:0];
	assign cnt_wr = wr_pend_q && (wr_idx_q == `TMR_IDX_CNT_L);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_idx_q <= '0;
		end else begin
			wr_pend_q <= wr_acc;
			if (wr_acc) begin
				wr_idx_q <= rd_idx;
			end
		end
	end

	always_comb begin
		rd_byte = 8'h00;
		case (rd_idx)
			`TMR_IDX_CAP_L: rd_byte = cap_q[7:0];
			`TMR_IDX_CAP_H: rd_byte = temp_q;
			`TMR_IDX_OCB_L: rd_byte = ocr_q[1][7:0];
			`TMR_IDX_OCB_H: rd_byte = ocr_q[1][15:8];
			`TMR_IDX_OCA_L: rd_byte = ocr_q[0][7:0];
			`TMR_IDX_OCA_H: rd_byte = ocr_q[0][15:8];
			`TMR_IDX_CNT_L: rd_byte = cnt_q[7:0];
			`TMR_IDX_CNT_H: rd_byte = temp_q;
			`TMR_IDX_CTL_B: rd_byte = ctlb_q & `TMR_CTLB_WMASK;
			`TMR_IDX_CTL_A: rd_byte = ctla_q & `TMR_CTLA_WMASK;
			`TMR_IDX_AUX: rd_byte = {5'h00, aux_q};
			`TMR_IDX_FLAG: rd_byte = {4'h0, flg_q};
			`TMR_IDX_MASK: rd_byte = {4'h0, msk_q};
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h00000000;
			hready_q <= 1'b1;
		end else begin
			hready_q <= 1'b1;
			if (rd_acc) begin
				hrdata_q <= {24'h000000, rd_byte};
			end
		end
	end
	assign hrdata = hrdata_q;
	assign hreadyout = hready_q;
	assign hresp = 1'b0;

	// a capture or counter low-byte read latches the high byte; it wins over a high write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			temp_q <= 8'h00;
		end else if (rd_acc && rd_idx == `TMR_IDX_CAP_L) begin
			temp_q <= cap_q[15:8];
		end else if (rd_acc && rd_idx == `TMR_IDX_CNT_L) begin
			temp_q <= cnt_q[15:8];
		end else if (wr_pend_q && (wr_idx_q == `TMR_IDX_CNT_H
				|| wr_idx_q == `TMR_IDX_OCA_H || wr_idx_q == `TMR_IDX_OCB_H)) begin
			temp_q <= wb;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctla_q <= `TMR_CTL_RST;
			ctlb_q <= `TMR_CTL_RST;
			aux_q <= '0;
			msk_q <= 4'h0;
		end else if (wr_pend_q) begin
			case (wr_idx_q)
				`TMR_IDX_CTL_A: ctla_q <= wb & `TMR_CTLA_WMASK;
				`TMR_IDX_CTL_B: ctlb_q <= wb & `TMR_CTLB_WMASK;
				`TMR_IDX_AUX: aux_q <= wb[2:0];
				`TMR_IDX_MASK: msk_q <= wb[3:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// counter
	// ----------------------------------------
	assign pwm_on = ctla_q.pwm_resolution != `TMR_PWM_OFF;

	always_comb begin
		case (ctla_q.pwm_resolution)
			`TMR_PWM_8: top = `TMR_TOP_8;
			`TMR_PWM_9: top = `TMR_TOP_9;
			default: top = `TMR_TOP_10;
		endcase
	end

	always_comb begin
		case (ctlb_q.clock_select)
			TMR_CS_STOP: tick = 1'b0;
			TMR_CS_CLK: tick = 1'b1;
			TMR_CS_DIV8: tick = pre_tap[0];
			TMR_CS_DIV64: tick = pre_tap[1];
			TMR_CS_DIV256: tick = pre_tap[2];
			TMR_CS_DIV1024: tick = pre_tap[3];
			TMR_CS_EXT_FALL: tick = sync_fall[0];
			TMR_CS_EXT_RISE: tick = sync_rise[0];
			default: tick = 1'b0;
		endcase
	end

	// a write wins over a pending clear and over a tick
	always_comb begin
		cnt_d = cnt_q;
		up_d = pwm_on ? up_q : 1'b1;
		cnt_step = 1'b0;
		if (cnt_wr) begin
			cnt_d = {temp_q, wb};
		end else if (clr_pend_q) begin
			cnt_d = '0;
		end else if (tick) begin
			cnt_step = 1'b1;
			if (!pwm_on) begin
				cnt_d = cnt_q + 1'b1;
			end else if (up_q) begin
				if (cnt_q >= top) begin
					up_d = 1'b0;
					cnt_d = cnt_q - 1'b1;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end else begin
				if (cnt_q == '0) begin
					up_d = 1'b1;
					cnt_d = cnt_q + 1'b1;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
		end
	end
	assign ovf_ev = cnt_step && cnt_d == '0 && (!pwm_on || !up_q);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= '0;
			up_q <= 1'b1;
		end else begin
			cnt_q <= cnt_d;
			up_q <= up_d;
		end
	end

	// the match is seen one cycle late, so the value past the match shows
	// for one cycle before the clear lands
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clr_pend_q <= 1'b0;
		end else begin
			clr_pend_q <= cnt_step && at_q[0] && ctlb_q.clear_on_match_a && !pwm_on;
		end
	end

	// ----------------------------------------
	// compare channels
	// ----------------------------------------
	assign com[0] = ctla_q.compare_a_pin_action;
	assign com[1] = ctla_q.compare_b_pin_action;
	assign dir = {aux_q.dir_b, aux_q.dir_a};

	for (genvar ch = 0; ch < 2; ch++) begin : g_ch
		localparam logic [`TMR_IDX_W-1:0] IDX_L = ch == 0 ? `TMR_IDX_OCA_L : `TMR_IDX_OCB_L;
		assign eff[ch] = pwm_on ? (obuf_q[ch] & `TMR_PWM_CMP_MASK) : ocr_q[ch];
		// only counting can hit: writes never raise a match
		assign hit[ch] = cnt_step && cnt_d == eff[ch];

		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				ocr_q[ch] <= '0;
				obuf_q[ch] <= '0;
			end else begin
				if (wr_pend_q && wr_idx_q == IDX_L) begin
					ocr_q[ch] <= {temp_q, wb};
				end
				// buffered at top so a pwm pulse never glitches mid-period
				if (!pwm_on || (cnt_step && up_q && cnt_q >= top)) begin
					obuf_q[ch] <= ocr_q[ch];
				end
			end
		end

		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				at_q[ch] <= 1'b0;
				hit_q[ch] <= 1'b0;
				hit_up_q[ch] <= 1'b0;
			end else begin
				hit_q[ch] <= hit[ch];
				hit_up_q[ch] <= up_q;
				if (cnt_step) begin
					at_q[ch] <= hit[ch];
				end else if (cnt_wr || clr_pend_q) begin
					at_q[ch] <= 1'b0;
				end
			end
		end

		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				oc_q[ch] <= 1'b0;
				oe_q[ch] <= 1'b0;
			end else begin
				oe_q[ch] <= dir[ch] && com[ch] != `TMR_COM_OFF
					&& !(pwm_on && com[ch] == `TMR_COM_TOGGLE);
				if (hit_q[ch] && pwm_on) begin
					// clear on the way up, set on the way down; high code inverts
					if (com[ch] == `TMR_COM_LOW) begin
						oc_q[ch] <= !hit_up_q[ch];
					end else if (com[ch] == `TMR_COM_HIGH) begin
						oc_q[ch] <= hit_up_q[ch];
					end
				end else if (hit_q[ch]) begin
					case (com[ch])
						`TMR_COM_TOGGLE: oc_q[ch] <= !oc_q[ch];
						`TMR_COM_LOW: oc_q[ch] <= 1'b0;
						`TMR_COM_HIGH: oc_q[ch] <= 1'b1;
						default: ;
					endcase
				end
			end
		end
	end
	assign compare_output_a = oc_q[0];
	assign compare_output_b = oc_q[1];
	assign compare_output_a_oe = oe_q[0];
	assign compare_output_b_oe = oe_q[1];

	// ----------------------------------------
	// input capture
	// ----------------------------------------
	assign cap_src = aux_q.cap_from_cmp ? sync_lvl[2] : sync_lvl[1];

	always_comb begin
		filt_d = filt_q;
		if (!ctlb_q.capture_noise_filter_en) begin
			filt_d = cap_src;
		end else if (&nc_q) begin
			filt_d = 1'b1;
		end else if (~|nc_q) begin
			filt_d = 1'b0;
		end
	end
	assign cap_ev = filt_d != filt_q && filt_d == ctlb_q.capture_edge_select;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nc_q <= 4'h0;
			filt_q <= 1'b0;
			cap_q <= '0;
		end else begin
			nc_q <= {nc_q[`TMR_NC_SAMPLES-2:0], cap_src};
			filt_q <= filt_d;
			if (cap_ev) begin
				cap_q <= cnt_q;
			end
		end
	end

	// ----------------------------------------
	// status flags
	// ----------------------------------------
	// write one to clear; a new event in the same cycle stays set
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flg_q <= 4'h0;
		end else begin
			flg_q <= (flg_q & ~((wr_pend_q && wr_idx_q == `TMR_IDX_FLAG) ? wb[3:0] : 4'h0))
				| {cap_ev, hit_q[1], hit_q[0], ovf_ev};
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_leave_a;
		cnt_step && at_q[0] && ctlb_q.clear_on_match_a && !pwm_on;
	endsequence
	sequence s_cleared;
		##1 (cnt_q == '0 || $past(cnt_wr));
	endsequence
	AST_CTC_CLEAR: assert property (s_leave_a |=> s_cleared)
		else $error("counter not cleared after channel A match");
	AST_CTC_PWM: assert property (pwm_on |=> !clr_pend_q)
		else $error("clear on match acted in pwm mode");
	AST_RSVD_ZERO: assert property (rd_acc && rd_idx == `TMR_IDX_CTL_A
			|=> hrdata[3:2] == 2'b00 && hrdata[31:8] == 24'h000000)
		else $error("reserved control A bits read nonzero");
	AST_RSVD_ZERO_B: assert property (rd_acc && rd_idx == `TMR_IDX_CTL_B
			|=> hrdata[5:4] == 2'b00 && hrdata[31:8] == 24'h000000)
		else $error("reserved control B bits read nonzero");
	AST_FLAG_A: assert property (hit_q[0] |=> flg_q[`TMR_FLG_CMPA])
		else $error("compare A flag not set after match");
	AST_WRITE_NO_HIT: assert property (cnt_wr |-> !hit[0] && !hit[1])
		else $error("counter write raised a match");
	AST_STOP: assert property (ctlb_q.clock_select == TMR_CS_STOP && !cnt_wr
			&& !clr_pend_q |=> $stable(cnt_q))
		else $error("stopped counter moved");
	AST_WRAP: assert property (!pwm_on && tick && !cnt_wr && !clr_pend_q
			&& cnt_q == 16'hFFFF |=> cnt_q == '0 && flg_q[`TMR_FLG_OVF])
		else $error("wrap without overflow flag");
	AST_PWM_RANGE: assert property (pwm_on && $stable(ctla_q) && cnt_q <= top
			&& !cnt_wr |=> cnt_q <= top)
		else $error("pwm counter left its range");
	AST_CAPTURE: assert property (cap_ev |=> cap_q == $past(cnt_q)
			&& flg_q[`TMR_FLG_CAP])
		else $error("capture did not copy counter");
	AST_FILTER: assert property (cap_ev && ctlb_q.capture_noise_filter_en
			|-> nc_q == {4{ctlb_q.capture_edge_select}})
		else $error("filtered capture without four equal samples");
	AST_TOGGLE: assert property (hit_q[0] && !pwm_on && com[0] == `TMR_COM_TOGGLE
			|=> oc_q[0] != $past(oc_q[0]))
		else $error("toggle action missing on channel A");
endmodule

// [dv/tmr_cpu.sv]
// cpu core model: AHB-Lite master issuing single byte-in-word transfers
// assumes hready is the slave's hreadyout; calls start right after a rising edge
`timescale 1ns/10ps
`include "tmr_consts.svh"
module tmr_cpu (
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	int stuck = 0;
	initial begin
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
	end
	// a slave that never answers is counted, the bench ends the run on it
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 16);
		if (hready !== 1'b1) stuck++;
	endtask
	task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
		output logic [7:0] rd);
		hsel <= 1'b1;
		haddr <= {24'h000000, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= {24'h000000, wd};
		wait_ready();
		rd = hrdata[7:0];
	endtask
	// high byte goes first so the low write moves both bytes at once
	task automatic wr16(input logic [5:0] idx, input logic [15:0] v);
		logic [7:0] x;
		xfer(1'b1, idx + 6'h01, v[15:8], x);
		xfer(1'b1, idx, v[7:0], x);
	endtask
	task automatic rd16(input logic [5:0] idx, output logic [15:0] v);
		xfer(1'b0, idx, 8'h00, v[7:0]);
		xfer(1'b0, idx + 6'h01, 8'h00, v[15:8]);
	endtask
endmodule

// [dv/test_sixteen_bit_timer_capture_compare.sv]
// self-checking bench for the 16-bit timer: registers, counting, compare, pwm, capture
// assumes tmr_pkg compiled first and the cpu model in dv/tmr_cpu.sv
`timescale 1ns/10ps
`include "tmr_consts.svh"
module test_sixteen_bit_timer_capture_compare
	import tmr_pkg::*;
;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic external_count_input, capture_input_pin, analog_cmp_i;
	logic compare_output_a, compare_output_a_oe, compare_output_b, compare_output_b_oe;
	int num_errors = 0;
	int n_checks = 0;
	int seed;
	logic [15:0] v, c, w;
	logic [7:0] f;
	logic pa, hi;
	tmr_timer1 tmr_timer1_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.external_count_input(external_count_input), .capture_input_pin(capture_input_pin),
		.analog_cmp_i(analog_cmp_i), .compare_output_a(compare_output_a),
		.compare_output_a_oe(compare_output_a_oe), .compare_output_b(compare_output_b),
		.compare_output_b_oe(compare_output_b_oe));
	tmr_cpu tmr_cpu_inst (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic give_verdict();
		num_errors += tmr_cpu_inst.stuck;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		logic [7:0] x;
		tmr_cpu_inst.xfer(1'b1, idx, d, x);
	endtask
	task automatic rd(input logic [5:0] idx, output logic [7:0] d);
		tmr_cpu_inst.xfer(1'b0, idx, 8'h00, d);
	endtask
	task automatic chk_rd(input string what, input logic [5:0] idx, input logic [7:0] e);
		logic [7:0] d;
		rd(idx, d);
		check(what, {8'h00, e}, {8'h00, d});
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge hclk);
	endtask
	function automatic int div_of(input int cs);
		case (cs)
			2: return 8;
			3: return 64;
			4: return 256;
			5: return 1024;
			default: return 1;
		endcase
	endfunction
	function automatic logic pin_next(input logic [1:0] code, input logic p);
		case (code)
			`TMR_COM_TOGGLE: return ~p;
			`TMR_COM_LOW: return 1'b0;
			`TMR_COM_HIGH: return 1'b1;
			default: return p;
		endcase
	endfunction
	function automatic logic [15:0] top_of(input int p);
		case (p)
			1: return `TMR_TOP_8;
			2: return `TMR_TOP_9;
			default: return `TMR_TOP_10;
		endcase
	endfunction
	// ------------------------------------------------------------
	// clock and watchdogs
	// ------------------------------------------------------------
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	initial begin
		wait_n(100000);
		num_errors++;
		give_verdict();
	end
	always @(posedge hclk) if (tmr_cpu_inst.stuck != 0) give_verdict();
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		seed = 62;
		hresetn = 1'b0;
		external_count_input = 1'b0;
		capture_input_pin = 1'b0;
		analog_cmp_i = 1'b0;
		wait_n(6);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk_rd("ctla_reset", `TMR_IDX_CTL_A, `TMR_CTL_RST);
		chk_rd("ctlb_reset", `TMR_IDX_CTL_B, `TMR_CTL_RST);
		wr(`TMR_IDX_CTL_A, 8'hFF);
		wr(`TMR_IDX_CTL_B, 8'hFF);
		chk_rd("ctla_rsvd", `TMR_IDX_CTL_A, `TMR_CTLA_WMASK);
		chk_rd("ctlb_rsvd", `TMR_IDX_CTL_B, `TMR_CTLB_WMASK);
		chk_rd("unmapped", 6'h3F, 8'h00);
		wr(`TMR_IDX_CTL_A, 8'h00);
		wr(`TMR_IDX_CTL_B, 8'h00);
		for (int cs = 0; cs < 6; cs++) begin
			tmr_cpu_inst.wr16(`TMR_IDX_CNT_L, 16'h0000);
			wr(`TMR_IDX_CTL_B, 8'(cs));
			wait_n(8 * div_of(cs));
			wr(`TMR_IDX_CTL_B, 8'h00);
			tmr_cpu_inst.rd16(`TMR_IDX_CNT_L, v);
			check("prescale", 16'h0001, 16'(cs == 0 ? v == 0 : v >= 7 && v <= 11));
		end
		// external pin stays an input: the timer never drives it
		for (int e = 0; e < 2; e++) begin
			tmr_cpu_inst.wr16(`TMR_IDX_CNT_L, 16'h0000);
			wr(`TMR_IDX_CTL_B, e == 1 ? 8'(TMR_CS_EXT_RISE) : 8'(TMR_CS_EXT_FALL));
			repeat (8) begin
				external_count_input <= 1'b1;
				wait_n(4);
				external_count_input <= 1'b0;
				wait_n(4);
			end
			wait_n(6);
			wr(`TMR_IDX_CTL_B, 8'h00);
			tmr_cpu_inst.rd16(`TMR_IDX_CNT_L, v);
			check("ext_count", 16'h0008, v);
		end
		c = 16'h0010 + 16'($unsigned($random(seed)) % 32);
		tmr_cpu_inst.wr16(`TMR_IDX_OCA_L, c);
		tmr_cpu_inst.wr16(`TMR_IDX_OCB_L, c);
		wr(`TMR_IDX_MASK, 8'h00);
		chk_rd("mask", `TMR_IDX_MASK, 8'h00);
		wr(`TMR_IDX_AUX, 8'h06);
		pa = 1'b0;
		for (int k = 3; k >= 0; k--) begin
			tmr_cpu_inst.wr16(`TMR_IDX_CNT_L, c);
			wr(`TMR_IDX_FLAG, 8'hFF);
			wr(`TMR_IDX_CTL_A, {2'(k), 2'(k), 4'h0});
			chk_rd("write_no_match", `TMR_IDX_FLAG, 8'h00);
			tmr_cpu_inst.wr16(`TMR_IDX_CNT_L, 16'h0000);
			wr(`TMR_IDX_CTL_B, 8'h01);
			wait_n(c + 8);
			wr(`TMR_IDX_CTL_B, 8'h00);
			pa = pin_next(2'(k), pa);
			rd(`TMR_IDX_FLAG, f);
			check("match_flags", 16'h0006, 16'(f & 8'h06));
			check("oe_a", 16'(k != 0), 16'(compare_output_a_oe));
			check("oe_b", 16'(k != 0), 16'(compare_output_b_oe));
			if (k != 0) check("pin_a", 16'(pa), 16'(compare_output_a));
			if (k != 0) check("pin_b", 16'(pa), 16'(compare_output_b));
		end
		for (int cs = 1; cs < 3; cs++) begin
			tmr_cpu_inst.wr16(`TMR_IDX_CNT_L, 16'h0000);
			wr(`TMR_IDX_CTL_B, 8'h08 | 8'(cs));
			repeat (4) begin
				wait_n(c * div_of(cs));
				tmr_cpu_inst.rd16(`TMR_IDX_CNT_L, v);
				check("ctc_bound", 16'h0001, 16'(v <= c + 1));
			end
		end
		for (int p = 1; p < 4; p++) begin
			wr(`TMR_IDX_CTL_A, 8'(p));
			wr(`TMR_IDX_CTL_B, 8'h09);
			hi = 1'b0;
			repeat (12) begin
				wait_n($unsigned($random(seed)) % 200);
				tmr_cpu_inst.rd16(`TMR_IDX_CNT_L, v);
				check("pwm_top", 16'h0001, 16'(v <= top_of(p)));
				if (v > c + 1) hi = 1'b1;
			end
			check("pwm_no_clear", 16'h0001, 16'(hi));
		end
		wr(`TMR_IDX_CTL_B, 8'h00);
		wr(`TMR_IDX_CTL_A, 8'h00);
		// capture: counter frozen so the captured value is known exactly
		w = 16'($random(seed));
		tmr_cpu_inst.wr16(`TMR_IDX_CNT_L, w);
		wr(`TMR_IDX_AUX, 8'h00);
		wr(`TMR_IDX_CTL_B, 8'h40);
		wait_n(8);
		wr(`TMR_IDX_FLAG, 8'hFF);
		capture_input_pin <= 1'b1;
		wait_n(8);
		tmr_cpu_inst.rd16(`TMR_IDX_CAP_L, v);
		check("cap_rise", w, v);
		rd(`TMR_IDX_FLAG, f);
		check("cap_flag", 16'h0001, 16'(f[`TMR_FLG_CAP]));
		wr(`TMR_IDX_CTL_B, 8'h80);
		wait_n(8);
		wr(`TMR_IDX_FLAG, 8'hFF);
		capture_input_pin <= 1'b0;
		wait_n(2);
		capture_input_pin <= 1'b1;
		wait_n(10);
		rd(`TMR_IDX_FLAG, f);
		check("filter_glitch", 16'h0000, 16'(f[`TMR_FLG_CAP]));
		capture_input_pin <= 1'b0;
		wait_n(10);
		rd(`TMR_IDX_FLAG, f);
		check("filter_fall", 16'h0001, 16'(f[`TMR_FLG_CAP]));
		tmr_cpu_inst.wr16(`TMR_IDX_CNT_L, ~w);
		wr(`TMR_IDX_AUX, 8'h01);
		wr(`TMR_IDX_CTL_B, 8'h40);
		wait_n(8);
		analog_cmp_i <= 1'b1;
		wait_n(8);
		tmr_cpu_inst.rd16(`TMR_IDX_CAP_L, v);
		check("cap_cmp", ~w, v);
		wr(`TMR_IDX_CTL_B, 8'h00);
		tmr_cpu_inst.wr16(`TMR_IDX_CNT_L, 16'hFFF0);
		wr(`TMR_IDX_FLAG, 8'hFF);
		wr(`TMR_IDX_CTL_B, 8'h01);
		wait_n(30);
		wr(`TMR_IDX_CTL_B, 8'h00);
		rd(`TMR_IDX_FLAG, f);
		check("ovf_flag", 16'h0001, 16'(f[`TMR_FLG_OVF]));
		tmr_cpu_inst.rd16(`TMR_IDX_CNT_L, v);
		check("wrap", 16'h0001, 16'(v < 16'h0020));
		wr(`TMR_IDX_FLAG, 8'h01);
		rd(`TMR_IDX_FLAG, f);
		check("ovf_clear", 16'h0000, 16'(f[`TMR_FLG_OVF]));
		give_verdict();
	end
endmodule
